//--- hw/cache_setup_cfg.svh
// Purpose: Constants for the cache setup configuration block.
// Assumes: Included by the package, the controller design file and the bench.
// Notes:   Chain layouts are low bit first as shifted in.
`ifndef CACHE_SETUP_CFG_SVH
`define CACHE_SETUP_CFG_SVH

`define OTC_LEN              16
`define OTC_RESET            16'h0000
`define RWC_LEN              24
`define RWC_ENABLE_BIT       0
`define RWC_SIZE_LSB         1
`define RWC_ITD_LSB          5
`define RWC_MODIFIED_LSB     7
`define RWC_SETUP_BIT        10
`define RWC_EVICT_BIT        11
`define RWC_DUP_EN_LSB       12
`define RWC_STS_LSB          15
`define RWC_BANK_BIT         19
`define RWC_RESET            24'h00_0000
`define IFACE_CFG_LEN        8
`define IFACE_CFG_RESET      8'h00
`define STS_VALID_DIRTY      4'h3

`endif

//--- hw/cache_setup_mode_config.sv
// Purpose: Configuration chains and setup-mode effects of the cache controller.
// Assumes: Boot ROM pins are asynchronous; core requests are on clock_i.
// Notes:   Chains are written serially, as the register access is documented.
`timescale 1ns/100ps
`include "cache_setup_cfg.svh"

// Function
// R1 - One-time chain loaded serially from boot ROM
// R2 - Rewritable chain reloadable by privileged writes
// R3 - Software sets enable, duplicate copies zero
// R4 - Software programs exact or maximum size
// R5 - Software sets invalidate-to-dirty and setup
// R6 - Software clears modified, evict, status, bank
// R7 - Setup mode makes L1 updates clean
// R8 - Setup mode forces L2 tag status
// R9 - Setup mode squashes victim writeback commands
// R10 - Setup creates blocks without interface traffic
// R11 - Software sweeps twice cache size
// R12 - Enable and size rewritable at run time
// R13 - Interface starts in reset default configuration
// R14 - Default configuration governs until reprogrammed
// R15 - Incompatible systems reprogram interface first
// R16 - Chip reset disables the L2 cache
// R17 - Warm reset and sleep clear rewritable chain
// R18 - Clearing setup restores normal behaviour
module cache_setup_mode_config
    import cache_setup_pkg::*;
(
    input  wire logic                      clock_i,
    input  wire logic                      rstn_i,
    input  wire logic                      otc_load_req_i,
    input  wire logic                      rom_data_i,
    input  wire logic                      rom_valid_i,
    output logic                           rom_enable_n_o,
    output logic                           otc_done_o,
    output cache_setup_pkg::otc_word_t     otc_value_o,
    input  wire logic                      rwc_shift_i,
    input  wire logic                      rwc_bit_i,
    input  wire logic                      rwc_init_i,
    input  wire logic                      iface_cfg_wr_i,
    input  wire logic [`IFACE_CFG_LEN-1:0] iface_cfg_data_i,
    output logic [`IFACE_CFG_LEN-1:0]      iface_cfg_o,
    output logic                           l2_cache_enable_o,
    output logic [3:0]                     l2_cache_size_o,
    output logic                           cache_setup_mode_o,
    input  wire logic                      l1_update_i,
    input  wire logic                      l1_update_dirty_i,
    output logic                           l1_block_dirty_o,
    input  wire logic                      l2_write_i,
    input  wire logic [3:0]                l2_coherent_sts_i,
    output logic                           l2_write_o,
    output logic [3:0]                     l2_tag_sts_o,
    input  wire logic                      victim_req_i,
    output logic                           victim_writeback_cmd_o,
    output logic                           victim_squashed_o
);
    import cache_setup_pkg::*;

    logic        rom_data_s1;
    logic        rom_data_s2;
    logic        rom_valid_s1;
    logic        rom_valid_s2;
    logic        rom_valid_s3;
    logic        load_s1;
    logic        load_s2;
    load_state_t state;
    load_state_t next_state;
    logic [$clog2(`OTC_LEN+1)-1:0] bit_count;
    logic [$clog2(`OTC_LEN+1)-1:0] next_bit_count;
    logic        otc_shift;
    logic        otc_init;
    rwc_word_t   rwc_value;
    logic [`IFACE_CFG_LEN-1:0] next_iface_cfg;
    logic        next_l1_dirty;
    logic [3:0]  next_tag_sts;
    logic        next_l2_write;
    logic        next_victim_cmd;
    logic        next_victim_squashed;
    logic        l2_enable_fld;
    logic [2:0]  dup_enable_fld;
    logic        setup_fld;
    logic        evict_fld;
    logic [3:0]  forced_sts_fld;

    function automatic logic [3:0] field4(input rwc_word_t w, input int lsb);
        field4 = w[lsb +: 4];
    endfunction

    // Boot ROM pins come from outside the clock domain
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rom_data_s1  <= 1'b0;
            rom_data_s2  <= 1'b0;
            rom_valid_s1 <= 1'b0;
            rom_valid_s2 <= 1'b0;
            rom_valid_s3 <= 1'b0;
            load_s1      <= 1'b0;
            load_s2      <= 1'b0;
        end else begin
            rom_data_s1  <= rom_data_i;
            rom_data_s2  <= rom_data_s1;
            rom_valid_s1 <= rom_valid_i;
            rom_valid_s2 <= rom_valid_s1;
            rom_valid_s3 <= rom_valid_s2;
            load_s1      <= otc_load_req_i;
            load_s2      <= load_s1;
        end
    end

    // R1 serial boot load
    always_comb begin
        next_state     = state;
        next_bit_count = bit_count;
        otc_shift      = 1'b0;
        otc_init       = 1'b0;
        case (state)
            ST_IDLE: begin
                if (load_s2) begin
                    next_state     = ST_LOAD;
                    next_bit_count = '0;
                    otc_init       = 1'b1;
                end
            end
            ST_LOAD: begin
                // Rising edge of the synchronised strobe takes one bit
                if (rom_valid_s2 && !rom_valid_s3) begin
                    otc_shift      = 1'b1;
                    next_bit_count = bit_count + 1'b1;
                    if (bit_count == ($clog2(`OTC_LEN+1))'(`OTC_LEN - 1)) begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                // One_time_config_chain: later load requests are ignored until reset
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state     <= ST_IDLE;
            bit_count <= '0;
        end else begin
            state     <= next_state;
            bit_count <= next_bit_count;
        end
    end

    assign rom_enable_n_o = (state != ST_LOAD);
    assign otc_done_o     = (state == ST_RUN);

    shift_chain #(
        .WIDTH     (`OTC_LEN),
        .RESET_VAL (64'(`OTC_RESET))
    ) u_otc (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .init_i  (otc_init),
        .shift_i (otc_shift),
        .bit_i   (rom_data_s2),
        .value_o (otc_value_o)
    );

    // R2 rewritable chain
    // R12 run-time rewrites
    // R17 warm reset init
    shift_chain #(
        .WIDTH     (`RWC_LEN),
        .RESET_VAL (64'(`RWC_RESET))
    ) u_rwc (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .init_i  (rwc_init_i),
        .shift_i (rwc_shift_i),
        .bit_i   (rwc_bit_i),
        .value_o (rwc_value)
    );

    assign l2_enable_fld  = rwc_value[`RWC_ENABLE_BIT];
    assign dup_enable_fld = rwc_value[`RWC_DUP_EN_LSB +: 3];
    assign setup_fld      = rwc_value[`RWC_SETUP_BIT];
    assign evict_fld      = rwc_value[`RWC_EVICT_BIT];
    assign forced_sts_fld = field4(rwc_value, `RWC_STS_LSB);

    // R16 reset disables cache
    // R3 duplicate copies also enable
    assign l2_cache_enable_o  = l2_enable_fld | (|dup_enable_fld);
    assign l2_cache_size_o    = field4(rwc_value, `RWC_SIZE_LSB);
    assign cache_setup_mode_o = setup_fld;

    // R13 default interface config
    // R14 held until rewritten
    always_comb begin
        next_iface_cfg = iface_cfg_o;
        if (iface_cfg_wr_i) begin
            next_iface_cfg = iface_cfg_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            iface_cfg_o <= `IFACE_CFG_RESET;
        end else begin
            iface_cfg_o <= next_iface_cfg;
        end
    end

    always_comb begin
        next_l1_dirty        = l1_block_dirty_o;
        next_l2_write        = l2_write_i & l2_cache_enable_o;
        next_tag_sts         = l2_tag_sts_o;
        next_victim_cmd      = 1'b0;
        next_victim_squashed = 1'b0;
        // R7 clean in setup
        // R18 normal dirty marking
        if (l1_update_i) begin
            next_l1_dirty = setup_fld ? 1'b0 : l1_update_dirty_i;
        end
        // R8 forced tag status
        if (l2_write_i) begin
            next_tag_sts = setup_fld ? forced_sts_fld : l2_coherent_sts_i;
        end
        // R9 victim squash
        // R10 no interface traffic
        if (victim_req_i) begin
            if (setup_fld) begin
                next_victim_squashed = 1'b1;
            end else begin
                next_victim_cmd = evict_fld | l2_cache_enable_o;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            l1_block_dirty_o       <= 1'b0;
            l2_write_o             <= 1'b0;
            l2_tag_sts_o           <= 4'h0;
            victim_writeback_cmd_o <= 1'b0;
            victim_squashed_o      <= 1'b0;
        end else begin
            l1_block_dirty_o       <= next_l1_dirty;
            l2_write_o             <= next_l2_write;
            l2_tag_sts_o           <= next_tag_sts;
            victim_writeback_cmd_o <= next_victim_cmd;
            victim_squashed_o      <= next_victim_squashed;
        end
    end

    a_l1_clean_setup: assert property (@(posedge clock_i) disable iff (!rstn_i) // R7
        (l1_update_i && setup_fld) |=> !l1_block_dirty_o)
        else $error("L1 block dirty after setup-mode update");

    a_l1_dirty_normal: assert property (@(posedge clock_i) disable iff (!rstn_i) // R18
        (l1_update_i && !setup_fld) |=> (l1_block_dirty_o == $past(l1_update_dirty_i)))
        else $error("L1 dirty mark lost in normal mode");

    a_forced_sts: assert property (@(posedge clock_i) disable iff (!rstn_i) // R8
        (l2_write_i && setup_fld) |=> (l2_tag_sts_o == $past(forced_sts_fld)))
        else $error("Tag status not forced in setup mode");

    a_victim_squash: assert property (@(posedge clock_i) disable iff (!rstn_i) // R9
        setup_fld |=> !victim_writeback_cmd_o)
        else $error("Victim command issued in setup mode");

    a_victim_normal: assert property (@(posedge clock_i) disable iff (!rstn_i) // R18
        (victim_req_i && !setup_fld && l2_cache_enable_o) |=> victim_writeback_cmd_o)
        else $error("Victim command missing in normal mode");

    a_rwc_init_off: assert property (@(posedge clock_i) disable iff (!rstn_i) // R17
        rwc_init_i |=> (!l2_cache_enable_o && !cache_setup_mode_o))
        else $error("Cache still on after chain init");

    a_otc_load_len: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
        (state == ST_LOAD && next_state == ST_RUN) |-> (bit_count == 5'd15))
        else $error("One-time chain loaded with wrong length");

    a_iface_hold: assert property (@(posedge clock_i) disable iff (!rstn_i) // R14
        !iface_cfg_wr_i |=> $stable(iface_cfg_o))
        else $error("Interface config changed without write");

    a_size_track: assert property (@(posedge clock_i) disable iff (!rstn_i) // R12
        (rwc_shift_i && !rwc_init_i) |=>
            (l2_cache_size_o == $past(rwc_value[`RWC_SIZE_LSB+1 +: 4])))
        else $error("Size output does not follow chain");

    a_write_gated: assert property (@(posedge clock_i) disable iff (!rstn_i) // R16
        !l2_cache_enable_o |=> !l2_write_o)
        else $error("L2 write passed while cache is off");

    c_setup_squash: cover property (@(posedge clock_i) disable iff (!rstn_i)
        victim_req_i && setup_fld);
    c_otc_done: cover property (@(posedge clock_i) disable iff (!rstn_i)
        state == ST_LOAD ##1 state == ST_RUN);
    c_forced_write: cover property (@(posedge clock_i) disable iff (!rstn_i)
        l2_write_i && setup_fld && l2_cache_enable_o);
    c_victim_normal: cover property (@(posedge clock_i) disable iff (!rstn_i)
        victim_req_i && !setup_fld && l2_cache_enable_o);
endmodule

//--- hw/cache_setup_pkg.sv
// Purpose: Types for the cache setup configuration block.
// Assumes: cache_setup_cfg.svh holds the numbers.
// Notes:   Types only.
`include "cache_setup_cfg.svh"

package cache_setup_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOAD,
        ST_RUN
    } load_state_t;

    typedef logic [`RWC_LEN-1:0] rwc_word_t;
    typedef logic [`OTC_LEN-1:0] otc_word_t;
endpackage

//--- hw/shift_chain.sv
// Purpose: Serial shift chain with parallel read-out register.
// Assumes: One bit shifted per enabled clock, low bit first.
// Notes:   Reset value is a parameter constant.
`timescale 1ns/100ps

module shift_chain #(
    parameter int          WIDTH     = 8,
    parameter logic [63:0] RESET_VAL = 64'h0000_0000_0000_0000
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic             init_i,
    input  wire logic             shift_i,
    input  wire logic             bit_i,
    output logic [WIDTH-1:0]      value_o
);
    logic [WIDTH-1:0] next_value;

    always_comb begin
        next_value = value_o;
        if (init_i) begin
            next_value = RESET_VAL[WIDTH-1:0];
        end else if (shift_i) begin
            next_value = {bit_i, value_o[WIDTH-1:1]};
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            value_o <= RESET_VAL[WIDTH-1:0];
        end else begin
            value_o <= next_value;
        end
    end
endmodule

//--- test/boot_rom_model.sv
// Purpose: Serial boot ROM seen from the cache controller's load pins.
// Assumes: The ROM runs while the device holds its enable low.
// Notes:   Strobe high for 4 clocks and low for 7 between bits, above the 3 required.
`timescale 1ns/100ps

module boot_rom_model #(
    parameter logic [15:0] WORD = 16'h0000
) (
    input  wire logic clock_i,
    input  wire logic rom_enable_n_i,
    output logic      rom_data_o,
    output logic      rom_valid_o
);
    initial begin
        rom_data_o = 1'b1;
        rom_valid_o = 1'b0;
        forever begin
            @(posedge clock_i iff rom_enable_n_i === 1'b0);
            // Low bit goes first so it ends in bit 0
            for (int i = 0; i < 16; i++) begin
                rom_data_o <= WORD[i];
                repeat (4) @(posedge clock_i);
                rom_valid_o <= 1'b1;
                repeat (4) @(posedge clock_i);
                rom_valid_o <= 1'b0;
                repeat (3) @(posedge clock_i);
            end
            // Released line shows the inverse, never a stale bit
            rom_data_o <= ~WORD[15];
            wait (rom_enable_n_i === 1'b1);
        end
    end
endmodule

//--- test/cache_setup_mode_config_bench.sv
// Purpose: Self-checking bench for the cache setup configuration block.
// Assumes: Chains are loaded low bit first, the rewritable one with one shift per clock.
// Notes:   Each scenario is one task; a watchdog cuts hangs short.
`timescale 1ns/100ps
`include "cache_setup_cfg.svh"

module cache_setup_mode_config_bench;
    import cache_setup_pkg::*;
    localparam otc_word_t ROM_WORD = 16'hC3A5;
    // Stands in for the cache size in blocks; the sweep covers twice it
    localparam int        SWEEP_BLOCKS = 8;
    logic                      clock_i, rstn_i, otc_load_req_i, rom_data_i, rom_valid_i;
    logic                      rom_enable_n_o, otc_done_o, rwc_shift_i, rwc_bit_i, rwc_init_i;
    logic                      iface_cfg_wr_i, l2_cache_enable_o, cache_setup_mode_o;
    logic                      l1_update_i, l1_update_dirty_i, l1_block_dirty_o, l2_write_i;
    logic                      l2_write_o, victim_req_i, victim_writeback_cmd_o, victim_squashed_o;
    logic [3:0]                l2_cache_size_o, l2_coherent_sts_i, l2_tag_sts_o;
    logic [`IFACE_CFG_LEN-1:0] iface_cfg_data_i, iface_cfg_o;
    otc_word_t                 otc_value_o;
    int                        err_total, num_checks;

    cache_setup_mode_config dut (
        .clock_i                (clock_i),
        .rstn_i                 (rstn_i),
        .otc_load_req_i         (otc_load_req_i),
        .rom_data_i             (rom_data_i),
        .rom_valid_i            (rom_valid_i),
        .rom_enable_n_o         (rom_enable_n_o),
        .otc_done_o             (otc_done_o),
        .otc_value_o            (otc_value_o),
        .rwc_shift_i            (rwc_shift_i),
        .rwc_bit_i              (rwc_bit_i),
        .rwc_init_i             (rwc_init_i),
        .iface_cfg_wr_i         (iface_cfg_wr_i),
        .iface_cfg_data_i       (iface_cfg_data_i),
        .iface_cfg_o            (iface_cfg_o),
        .l2_cache_enable_o      (l2_cache_enable_o),
        .l2_cache_size_o        (l2_cache_size_o),
        .cache_setup_mode_o     (cache_setup_mode_o),
        .l1_update_i            (l1_update_i),
        .l1_update_dirty_i      (l1_update_dirty_i),
        .l1_block_dirty_o       (l1_block_dirty_o),
        .l2_write_i             (l2_write_i),
        .l2_coherent_sts_i      (l2_coherent_sts_i),
        .l2_write_o             (l2_write_o),
        .l2_tag_sts_o           (l2_tag_sts_o),
        .victim_req_i           (victim_req_i),
        .victim_writeback_cmd_o (victim_writeback_cmd_o),
        .victim_squashed_o      (victim_squashed_o)
    );
    boot_rom_model #(.WORD(ROM_WORD)) rom (.clock_i(clock_i), .rom_enable_n_i(rom_enable_n_o),
        .rom_data_o(rom_data_i), .rom_valid_o(rom_valid_i));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_chain(input rwc_word_t w);
        for (int i = 0; i < `RWC_LEN; i++) begin
            @(posedge clock_i);
            rwc_shift_i <= 1'b1;
            rwc_bit_i <= w[i];
        end
        @(posedge clock_i);
        rwc_shift_i <= 1'b0;
        @(posedge clock_i);
        #1;
    endtask

    // One dirty L1 update, one L2 write and one victim request together
    task automatic traffic(input logic setup, input logic [3:0] sts);
        @(posedge clock_i);
        l1_update_i <= 1'b1;
        l1_update_dirty_i <= 1'b1;
        l2_write_i <= 1'b1;
        l2_coherent_sts_i <= 4'h9;
        victim_req_i <= 1'b1;
        @(posedge clock_i);
        l1_update_i <= 1'b0;
        l2_write_i <= 1'b0;
        victim_req_i <= 1'b0;
        #1;
        chk("l1_dirty", !setup, l1_block_dirty_o);
        chk("l2_sts", sts, l2_tag_sts_o);
        chk("l2_write", 1'b1, l2_write_o);
        chk("victim_cmd", !setup, victim_writeback_cmd_o);
        chk("victim_squash", setup, victim_squashed_o);
        @(posedge clock_i);
        #1;
        chk("victim_cmd_end", 1'b0, victim_writeback_cmd_o);
    endtask

    task automatic t_reset_iface();
        chk("rom_en_n", 1'b1, rom_enable_n_o);
        chk("l2_en", 1'b0, l2_cache_enable_o);
        chk("iface", 8'h00, iface_cfg_o);
        @(posedge clock_i);
        iface_cfg_wr_i <= 1'b1;
        iface_cfg_data_i <= 8'hA5;
        @(posedge clock_i);
        iface_cfg_wr_i <= 1'b0;
        #1;
        chk("iface", 8'hA5, iface_cfg_o);
    endtask

    task automatic t_otc_load();
        @(posedge clock_i);
        otc_load_req_i <= 1'b1;
        for (int n = 0; n < 3000 && otc_done_o !== 1'b1; n++) @(posedge clock_i);
        otc_load_req_i <= 1'b0;
        #1;
        chk("otc_done", 1'b1, otc_done_o);
        chk("otc_value", ROM_WORD, otc_value_o);
        @(posedge clock_i);
        otc_load_req_i <= 1'b1;
        repeat (20) @(posedge clock_i);
        otc_load_req_i <= 1'b0;
        #1;
        chk("rom_en_n", 1'b1, rom_enable_n_o);
        chk("otc_value", ROM_WORD, otc_value_o);
    endtask

    // Enable 1, size 15, invalidate-to-dirty 1, setup 1, rest 0
    task automatic t_setup();
        write_chain(24'h00_043F);
        chk("l2_en", 1'b1, l2_cache_enable_o);
        chk("l2_size", 4'hF, l2_cache_size_o);
        chk("setup", 1'b1, cache_setup_mode_o);
        traffic(1'b1, 4'h0);
    endtask

    // Invalidate sweep: back-to-back writes over twice the cache, still in setup
    task automatic t_sweep();
        @(posedge clock_i);
        l2_write_i <= 1'b1;
        l2_coherent_sts_i <= `STS_VALID_DIRTY;
        victim_req_i <= 1'b1;
        repeat (2 * SWEEP_BLOCKS) begin
            @(posedge clock_i);
            #1;
            chk("sweep_sts", 4'h0, l2_tag_sts_o);
            chk("sweep_write", 1'b1, l2_write_o);
            chk("sweep_squash", 1'b1, victim_squashed_o);
        end
        @(posedge clock_i);
        l2_write_i <= 1'b0;
        victim_req_i <= 1'b0;
    endtask

    // Size 3, evict on, setup off, then warm init of the chain
    task automatic t_normal_init();
        write_chain(24'h00_0807);
        chk("l2_size", 4'h3, l2_cache_size_o);
        chk("setup", 1'b0, cache_setup_mode_o);
        traffic(1'b0, 4'h9);
        @(posedge clock_i);
        rwc_init_i <= 1'b1;
        @(posedge clock_i);
        rwc_init_i <= 1'b0;
        #1;
        chk("l2_en", 1'b0, l2_cache_enable_o);
        chk("l2_size", 4'h0, l2_cache_size_o);
        // Cache off: writes and victims must not reach the interface
        @(posedge clock_i);
        l2_write_i <= 1'b1;
        victim_req_i <= 1'b1;
        @(posedge clock_i);
        l2_write_i <= 1'b0;
        victim_req_i <= 1'b0;
        #1;
        chk("l2_write_off", 1'b0, l2_write_o);
        chk("victim_off", 1'b0, victim_writeback_cmd_o);
        // A duplicate enable copy alone turns the cache on
        write_chain(24'h00_1000);
        chk("l2_en_dup", 1'b1, l2_cache_enable_o);
    endtask

    task automatic t_chip_reset();
        write_chain(24'h00_043F);
        @(posedge clock_i);
        rstn_i <= 1'b0;
        @(posedge clock_i);
        rstn_i <= 1'b1;
        #1;
        chk("l2_en", 1'b0, l2_cache_enable_o);
        chk("setup", 1'b0, cache_setup_mode_o);
        chk("otc_done_rst", 1'b0, otc_done_o);
    endtask

    initial begin
        {rstn_i, otc_load_req_i, rwc_shift_i, rwc_bit_i, rwc_init_i, iface_cfg_wr_i} = '0;
        {l1_update_i, l1_update_dirty_i, l2_write_i, victim_req_i} = '0;
        iface_cfg_data_i = '0;
        l2_coherent_sts_i = '0;
        err_total = 0;
        num_checks = 0;
        repeat (6) @(posedge clock_i);
        rstn_i <= 1'b1;
        #1;
        t_reset_iface();
        t_otc_load();
        t_setup();
        t_sweep();
        t_normal_init();
        t_chip_reset();
        give_verdict();
    end

    // Whole run needs well under a thousand clocks
    initial begin
        repeat (10000) @(posedge clock_i);
        err_total++;
        give_verdict();
    end
endmodule
